// [aib_hub.sv]
// analog interface bus hub: four-way bus arbiter, trigger router, end-of-conversion combiner
// assumes requesters hold req stable until their one-cycle ack and analog side answers next cycle
`timescale 1ns/1ps
`default_nettype none
module aib_hub (
	input wire logic clk_sys,
	input wire logic reset,
	input wire aib_pkg::aib_bus_req_t [aib_pkg::NUM_PORT-1:0] bus_req,
	output logic [aib_pkg::NUM_PORT-1:0] port_ack,
	output logic port_err,
	output logic [aib_pkg::DATA_W-1:0] port_rdata,
	output var aib_pkg::aib_bus_req_t ana_req,
	input wire logic [aib_pkg::DATA_W-1:0] ana_rdata,
	input wire logic [aib_pkg::NUM_SRC-1:0] soc_src,
	input wire logic [aib_pkg::NUM_TRIG-1:0][aib_pkg::SEL_W-1:0] trigger_source_select,
	input wire logic [aib_pkg::NUM_CH-1:0][aib_pkg::RES_W-1:0] ain_first,
	input wire logic [aib_pkg::NUM_CH-1:0][aib_pkg::RES_W-1:0] ain_second,
	output logic [aib_pkg::NUM_TRIG-1:0] int_master,
	output logic [aib_pkg::NUM_TRIG-1:0] int_peripheral_interrupt_expander,
	output logic [aib_pkg::NUM_DMA_INT-1:0] int_dma
);

	aib_pkg::aib_hub_state_t state, next_state;
	logic [aib_pkg::PORT_W-1:0] gnt, next_gnt, last, next_last;
	aib_pkg::aib_bus_req_t cur, next_cur, next_ana;
	logic [aib_pkg::NUM_PORT-1:0] next_ack;
	logic next_err;
	logic [aib_pkg::DATA_W-1:0] next_rdata;
	logic [aib_pkg::NUM_TRIG-1:0] soc_trig, next_trig, next_int;
	logic [aib_pkg::NUM_TRIG-1:0] eoc_first, eoc_second;
	logic [aib_pkg::RES_W-1:0] res_first, res_second;

	function automatic logic access_ok(input logic [aib_pkg::PORT_W-1:0] who,
		input aib_pkg::aib_bus_req_t r);
		logic ok;
		if (r.addr < aib_pkg::RES_LIMIT) begin
			ok = !r.we;
		end else begin
			ok = (who == aib_pkg::PORT_C_CPU);
		end
		return ok;
	endfunction : access_ok

	always_comb begin
		logic found;
		logic [aib_pkg::PORT_W-1:0] cand, pick;
		logic [aib_pkg::NUM_PORT-1:0] eff;
		found = 1'b0;
		cand = '0;
		pick = '0;
		eff = '0;
		next_state = state;
		next_gnt = gnt;
		next_last = last;
		next_cur = cur;
		next_ana = '0;
		next_ack = '0;
		next_err = port_err;
		next_rdata = port_rdata;
		// a port just acked is masked only in its ack cycle; a req still held after that is seen again
		for (int i = 0; i < aib_pkg::NUM_PORT; i++) begin
			eff[i] = bus_req[i].req & ~port_ack[i];
		end
		for (int i = 1; i <= aib_pkg::NUM_PORT; i++) begin
			cand = last + aib_pkg::PORT_W'(i);
			if (!found && eff[cand]) begin
				found = 1'b1;
				pick = cand;
			end
		end
		unique case (state)
			aib_pkg::H_IDLE: begin
				if (found) begin
					next_gnt = pick;
					next_last = pick;
					next_cur = bus_req[pick];
					// refused cycles never reach the analog side
					if (access_ok(pick, bus_req[pick]) && bus_req[pick].addr >= aib_pkg::RES_LIMIT) begin
						next_ana = bus_req[pick];
					end
					next_state = aib_pkg::H_ISSUE;
				end
			end
			aib_pkg::H_ISSUE: begin
				next_state = aib_pkg::H_CAPTURE;
			end
			aib_pkg::H_CAPTURE: begin
				next_ack[gnt] = 1'b1;
				next_err = !access_ok(gnt, cur);
				if (!access_ok(gnt, cur) || cur.we) begin
					next_rdata = '0;
				end else if (cur.addr < aib_pkg::RES_LIMIT) begin
					next_rdata = cur.addr[aib_pkg::CONV_SEL_BIT] ?
						aib_pkg::DATA_W'(res_second) : aib_pkg::DATA_W'(res_first);
				end else begin
					next_rdata = ana_rdata;
				end
				next_state = aib_pkg::H_IDLE;
			end
			default: begin
				next_state = aib_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= aib_pkg::H_IDLE;
			gnt <= '0;
			last <= aib_pkg::PORT_C_DMA;
			cur <= '0;
			ana_req <= '0;
			port_ack <= '0;
			port_err <= 1'b0;
			port_rdata <= '0;
		end else begin
			state <= next_state;
			gnt <= next_gnt;
			last <= next_last;
			cur <= next_cur;
			ana_req <= next_ana;
			port_ack <= next_ack;
			port_err <= next_err;
			port_rdata <= next_rdata;
		end
	end

	always_comb begin
		for (int k = 0; k < aib_pkg::NUM_TRIG; k++) begin
			// out-of-range selects give a dead trigger rather than a wrapped source
			if (trigger_source_select[k] < aib_pkg::SRC_LIMIT) begin
				next_trig[k] = soc_src[trigger_source_select[k]];
			end else begin
				next_trig[k] = 1'b0;
			end
		end
		// relies on both converters finishing a shared trigger in the same cycle
		next_int = eoc_first & eoc_second;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			soc_trig <= '0;
			int_master <= '0;
			int_peripheral_interrupt_expander <= '0;
			int_dma <= '0;
		end else begin
			soc_trig <= next_trig;
			int_master <= next_int;
			int_peripheral_interrupt_expander <= next_int;
			int_dma <= next_int[aib_pkg::NUM_DMA_INT-1:0];
		end
	end

	aib_converter u_first_converter (
		.clk_sys(clk_sys),
		.reset(reset),
		.soc(soc_trig),
		.ain(ain_first),
		.rd_index(cur.addr[aib_pkg::CH_W-1:0]),
		.rd_data(res_first),
		.eoc(eoc_first)
	);

	aib_converter u_second_converter (
		.clk_sys(clk_sys),
		.reset(reset),
		.soc(soc_trig),
		.ain(ain_second),
		.rd_index(cur.addr[aib_pkg::CH_W-1:0]),
		.rd_data(res_second),
		.eoc(eoc_second)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_taken(int p);
		state == aib_pkg::H_IDLE && next_state == aib_pkg::H_ISSUE && next_gnt == p;
	endsequence
	sequence s_ack_pulse(int p);
		port_ack[p] ##1 !port_ack[p];
	endsequence

	a_grant_one_hot: assert property ($onehot0(port_ack))
		else $error("two ports acked at once");
	// taking cycle, issue, capture, then the ack cycle
	a_ack_two_after: assert property (s_taken(0) |-> ##3 s_ack_pulse(0))
		else $error("ack not two cycles after grant");
	a_stall_bound: assert property ((bus_req[3].req && !port_ack[3]) |-> ##[1:15] port_ack[3])
		else $error("requester starved");
	a_master_refused: assert property ((state == aib_pkg::H_CAPTURE && gnt[1] == 1'b0 &&
		cur.addr >= aib_pkg::RES_LIMIT) |=> (port_err && port_rdata == '0))
		else $error("master access to analog register not refused");
	a_result_read_ok: assert property ((state == aib_pkg::H_CAPTURE && !cur.we &&
		cur.addr < aib_pkg::RES_LIMIT) |=> !port_err)
		else $error("result read refused");
	a_cpu_reaches_ana: assert property ((state == aib_pkg::H_IDLE &&
		next_state == aib_pkg::H_ISSUE &&
		next_gnt == aib_pkg::PORT_C_CPU && next_cur.addr >= aib_pkg::RES_LIMIT) |=>
		(ana_req.req && state == aib_pkg::H_ISSUE) ##1 !ana_req.req)
		else $error("control cpu cycle not forwarded for one cycle");
	a_trig_route_lat: assert property ((trigger_source_select[0] < aib_pkg::SRC_LIMIT &&
		soc_src[trigger_source_select[0]]) |=> soc_trig[0])
		else $error("trigger source not routed in one cycle");
	a_trig_dead_sel: assert property ((trigger_source_select[7] >= aib_pkg::SRC_LIMIT) |=>
		!soc_trig[7])
		else $error("invalid select produced a trigger");
	a_eoc_and: assert property ((eoc_first[2] && eoc_second[2]) |=>
		(int_master[2] && int_peripheral_interrupt_expander[2] && int_dma[2]))
		else $error("combined interrupt missing");
	a_eoc_single_side: assert property ((eoc_first[5] && !eoc_second[5]) |=> !int_master[5])
		else $error("interrupt raised from one converter only");
	a_int_needs_both: assert property (int_master[5] |-> $past(eoc_first[5] && eoc_second[5]))
		else $error("interrupt without both converter events one cycle before");
	a_dma_subset: assert property (int_dma ==
		int_peripheral_interrupt_expander[aib_pkg::NUM_DMA_INT-1:0])
		else $error("dma interrupts differ from expander lines");

endmodule : aib_hub
`default_nettype wire

// [aib_pkg.sv]
// shared constants, bus carriers and state codes for the analog interface bus hub
// assumes one 50 MHz system clock and an active-high asynchronous reset
package aib_pkg;

	localparam int NUM_PORT = 4;
	localparam int PORT_W = 2;
	localparam int NUM_SRC = 22;
	localparam int NUM_TRIG = 8;
	localparam int SLOT_W = 3;
	localparam int NUM_DMA_INT = 4;
	localparam int SEL_W = 5;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int RES_W = 12;
	localparam int NUM_CH = 16;
	localparam int CH_W = 4;
	localparam int CNT_W = 4;

	// requester slots on the digital side
	localparam logic [PORT_W-1:0] PORT_M_CPU = 2'h0;
	localparam logic [PORT_W-1:0] PORT_M_DMA = 2'h1;
	localparam logic [PORT_W-1:0] PORT_C_CPU = 2'h2;
	localparam logic [PORT_W-1:0] PORT_C_DMA = 2'h3;

	// result registers sit below this address, converter picked by one bit
	localparam logic [ADDR_W-1:0] RES_LIMIT = 8'h20;
	localparam int CONV_SEL_BIT = 4;
	localparam logic [SEL_W-1:0] SRC_LIMIT = 5'h16;

	// conversion time per sample-hold unit
	localparam int CLK_NS = 20;
	localparam int CONV_NS = 100;
	localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic req;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} aib_bus_req_t;

	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_HOLD_A = 2'b01,
		C_HOLD_B = 2'b10
	} aib_conv_state_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_ISSUE = 2'b01,
		H_CAPTURE = 2'b10
	} aib_hub_state_t;

endpackage : aib_pkg

// [aib_converter.sv]
// one converter: trigger queue, paired sample-hold, sequential conversion, result store
// assumes ain holds the digitised front-end codes, stable while sampled
`timescale 1ns/1ps
`default_nettype none
module aib_converter (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [aib_pkg::NUM_TRIG-1:0] soc,
	input wire logic [aib_pkg::NUM_CH-1:0][aib_pkg::RES_W-1:0] ain,
	input wire logic [aib_pkg::CH_W-1:0] rd_index,
	output logic [aib_pkg::RES_W-1:0] rd_data,
	output logic [aib_pkg::NUM_TRIG-1:0] eoc
);

	// eoc is registered one edge after the last count of unit b
	localparam int EOC_LAT = 2 * aib_pkg::CONV_CYC + 1;

	aib_pkg::aib_conv_state_t state, next_state;
	logic [aib_pkg::NUM_TRIG-1:0] pending, next_pending;
	logic [aib_pkg::SLOT_W-1:0] slot, next_slot;
	logic [aib_pkg::RES_W-1:0] samp_a, next_samp_a, samp_b, next_samp_b;
	logic [aib_pkg::CNT_W-1:0] cnt, next_cnt;
	logic [aib_pkg::NUM_CH-1:0][aib_pkg::RES_W-1:0] result, next_result;
	logic [aib_pkg::NUM_TRIG-1:0] next_eoc;

	always_comb begin
		logic found;
		logic [aib_pkg::SLOT_W-1:0] pick;
		found = 1'b0;
		pick = '0;
		next_state = state;
		next_slot = slot;
		next_samp_a = samp_a;
		next_samp_b = samp_b;
		next_cnt = cnt;
		next_result = result;
		next_eoc = '0;
		next_pending = pending;
		for (int i = aib_pkg::NUM_TRIG - 1; i >= 0; i--) begin
			if (pending[i]) begin
				found = 1'b1;
				pick = aib_pkg::SLOT_W'(i);
			end
		end
		unique case (state)
			aib_pkg::C_IDLE: begin
				// starts only from a queued trigger
				if (found) begin
					// both units sample in the same cycle
					next_samp_a = ain[{1'b0, pick}];
					next_samp_b = ain[{1'b1, pick}];
					next_slot = pick;
					next_pending[pick] = 1'b0;
					next_cnt = aib_pkg::CNT_W'(aib_pkg::CONV_CYC - 1);
					next_state = aib_pkg::C_HOLD_A;
				end
			end
			aib_pkg::C_HOLD_A: begin
				if (cnt == '0) begin
					next_result[{1'b0, slot}] = samp_a;
					next_cnt = aib_pkg::CNT_W'(aib_pkg::CONV_CYC - 1);
					next_state = aib_pkg::C_HOLD_B;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			aib_pkg::C_HOLD_B: begin
				// second unit waits for the shared mux and converter
				if (cnt == '0) begin
					next_result[{1'b1, slot}] = samp_b;
					next_eoc[slot] = 1'b1;
					next_state = aib_pkg::C_IDLE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = aib_pkg::C_IDLE;
			end
		endcase
		// a new trigger wins over the clear of its own slot
		next_pending = next_pending | soc;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= aib_pkg::C_IDLE;
			pending <= '0;
			slot <= '0;
			samp_a <= '0;
			samp_b <= '0;
			cnt <= '0;
			result <= '0;
			eoc <= '0;
			rd_data <= '0;
		end else begin
			state <= next_state;
			pending <= next_pending;
			slot <= next_slot;
			samp_a <= next_samp_a;
			samp_b <= next_samp_b;
			cnt <= next_cnt;
			result <= next_result;
			eoc <= next_eoc;
			rd_data <= result[rd_index];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_start;
		state == aib_pkg::C_IDLE && (|pending);
	endsequence
	sequence s_done;
		|eoc;
	endsequence

	a_conv_eoc_latency: assert property (s_start |-> ##EOC_LAT s_done)
		else $error("end of conversion not at fixed latency");
	a_conv_eoc_single: assert property ($onehot0(eoc))
		else $error("more than one end of conversion at once");
	a_conv_pair_stored: assert property ((state == aib_pkg::C_HOLD_B && cnt == '0) |=>
		(result[{1'b1, $past(slot)}] == $past(samp_b) && eoc != '0))
		else $error("second sample not stored with its event");

endmodule : aib_converter
`default_nettype wire

// [aib_ana_model.sv]
// analog-side register model answering accesses forwarded by the hub
// assumes ana_req pulses one cycle and its read data is sampled the next cycle
`timescale 1ns/1ps
`default_nettype none
module aib_ana_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire aib_pkg::aib_bus_req_t ana_req,
	output logic [aib_pkg::DATA_W-1:0] ana_rdata
);
	logic [aib_pkg::DATA_W-1:0] regs [0:255];
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ana_rdata <= 16'h0000;
		end else if (ana_req.req && ana_req.we) begin
			regs[ana_req.addr] <= ana_req.wdata;
			ana_rdata <= ~ana_rdata;
		end else if (ana_req.req) begin
			ana_rdata <= regs[ana_req.addr];
		end else begin
			// toggles when idle so stale data never looks valid
			ana_rdata <= ~ana_rdata;
		end
	end
endmodule : aib_ana_model
`default_nettype wire

// [analog_interface_bus_router_tb.sv]
// self-checking bench for the hub: bus arbitration, refusals, trigger and interrupt paths
// assumes the analog side is the register model beside it
`timescale 1ns/1ps
`default_nettype none
module analog_interface_bus_router_tb;
	logic clk_sys;
	logic reset;
	aib_pkg::aib_bus_req_t [3:0] bus_req;
	logic [3:0] port_ack;
	logic port_err;
	logic [15:0] port_rdata;
	aib_pkg::aib_bus_req_t ana_req;
	logic [15:0] ana_rdata;
	logic [21:0] soc_src;
	logic [7:0][4:0] tsel;
	logic [15:0][11:0] ain_first;
	logic [15:0][11:0] ain_second;
	logic [7:0] int_master;
	logic [7:0] int_pie;
	logic [3:0] int_dma;
	int checks, error_cnt, cyc, ana_cnt, last, n, s;
	int cnt_int[8], cnt_pie[8], cnt_dma[4];
	int mf[16], ms[16], af[16], as[16], wd[4];
	int acks[$];

	aib_hub i_aib_hub (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
		.port_ack(port_ack), .port_err(port_err), .port_rdata(port_rdata),
		.ana_req(ana_req), .ana_rdata(ana_rdata), .soc_src(soc_src),
		.trigger_source_select(tsel), .ain_first(ain_first), .ain_second(ain_second),
		.int_master(int_master), .int_peripheral_interrupt_expander(int_pie),
		.int_dma(int_dma));
	aib_ana_model i_aib_ana_model (.clk_sys(clk_sys), .reset(reset), .ana_req(ana_req),
		.ana_rdata(ana_rdata));

	task automatic results();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp=%0h seen=%0h", nm, exp, seen);
		end
	endtask : chk

	// one bus cycle: request held until the ack is seen, released on the next edge
	task automatic xfer(input int p, input logic we, input logic [7:0] a,
		input logic [15:0] d, input logic e, input logic [15:0] x);
		int w;
		@(posedge clk_sys);
		bus_req[p] <= '{req: 1'b1, we: we, addr: a, wdata: d};
		w = 0;
		do begin
			@(negedge clk_sys);
			w++;
		end while (port_ack[p] !== 1'b1 && w < 40);
		chk("ack_wait", w < 40, 1);
		chk("err", port_err, e);
		chk("rdata", port_rdata, x);
		// round-robin model: the pointer follows the last port served
		last = p;
		@(posedge clk_sys);
		bus_req[p].req <= 1'b0;
	endtask : xfer

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (!reset) begin
			cyc++;
			if (cyc > 6000) begin
				error_cnt++;
				results();
			end
			chk("ack_onehot", $countones(port_ack) <= 1, 1);
			chk("int_pie", int_pie, int_master);
			chk("int_dma", int_dma, int_master[3:0]);
			for (int j = 0; j < 8; j++) begin
				cnt_int[j] += int_master[j];
				cnt_pie[j] += int_pie[j];
			end
			for (int j = 0; j < 4; j++) cnt_dma[j] += int_dma[j];
			ana_cnt += ana_req.req;
			if (port_ack != 4'h0) acks.push_back($clog2(port_ack));
		end
	end

	initial begin
		reset = 1'b1;
		bus_req = '0;
		soc_src = 22'h0;
		tsel = '1;
		ain_first = '0;
		ain_second = '0;
		void'($urandom(32'hd141_0910));
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		for (int r = 0; r < 2; r++) begin
			for (int k = 0; k < 8; k++) begin
				@(posedge clk_sys);
				for (int c = 0; c < 16; c++) begin
					af[c] = $urandom_range(4095, 0);
					as[c] = $urandom_range(4095, 0);
					ain_first[c] <= af[c][11:0];
					ain_second[c] <= as[c][11:0];
				end
				s = $urandom_range(21, 0);
				// unused slots sit on both ends of the disabled range
				for (int j = 0; j < 8; j++) begin
					tsel[j] <= (j == k) ? s[4:0] : ((j % 2) ? 5'h1f : 5'h16);
				end
				if (r > 0) xfer(2, 1'b0, 8'h10 + k, 16'h0000, 1'b0, 16'(ms[k]));
				cnt_int = '{default: 0};
				cnt_pie = '{default: 0};
				cnt_dma = '{default: 0};
				@(posedge clk_sys);
				soc_src <= 22'($urandom) | (22'h1 << s);
				@(posedge clk_sys);
				soc_src <= 22'h0;
				repeat (40) @(posedge clk_sys);
				for (int j = 0; j < 8; j++) chk("int_cnt", cnt_int[j], j == k);
				for (int j = 0; j < 8; j++) chk("pie_cnt", cnt_pie[j], j == k);
				for (int j = 0; j < 4; j++) chk("dma_cnt", cnt_dma[j], j == k);
				mf[k] = af[k];
				mf[k + 8] = af[k + 8];
				ms[k] = as[k];
				ms[k + 8] = as[k + 8];
				xfer(k % 4, 1'b0, 8'(k), 16'h0000, 1'b0, 16'(mf[k]));
				xfer((k + 1) % 4, 1'b0, 8'(k + 8), 16'h0000, 1'b0, 16'(mf[k + 8]));
				xfer((k + 2) % 4, 1'b0, 8'(k + 16), 16'h0000, 1'b0, 16'(ms[k]));
				xfer((k + 3) % 4, 1'b0, 8'(k + 24), 16'h0000, 1'b0, 16'(ms[k + 8]));
			end
		end
		for (int i = 0; i < 4; i++) begin
			wd[i] = $urandom_range(65535, 0);
			xfer(2, 1'b1, 8'h40 + i, wd[i][15:0], 1'b0, 16'h0000);
		end
		for (int p = 0; p < 4; p++) begin
			n = ana_cnt;
			xfer(p, 1'b0, 8'h40 + p, 16'h0000, p != 2, (p == 2) ? wd[p][15:0] : 16'h0000);
			chk("ana_fwd", ana_cnt - n, p == 2);
			xfer(p, 1'b1, 8'h05, 16'h1234, 1'b1, 16'h0000);
		end
		// the monitor logs an ack on the edge the task returns on
		@(negedge clk_sys);
		n = last;
		acks.delete();
		fork
			xfer(0, 1'b0, 8'h01, 16'h0000, 1'b0, 16'(mf[1]));
			xfer(1, 1'b0, 8'h12, 16'h0000, 1'b0, 16'(ms[2]));
			xfer(2, 1'b0, 8'h42, 16'h0000, 1'b0, wd[2][15:0]);
			xfer(3, 1'b0, 8'h1b, 16'h0000, 1'b0, 16'(ms[11]));
		join
		@(negedge clk_sys);
		chk("grant_cnt", acks.size(), 4);
		for (int i = 0; i < 4; i++) chk("grant_order", acks[i], (n + 1 + i) % 4);
		results();
	end
endmodule : analog_interface_bus_router_tb
`default_nettype wire
